// ### design/rftc_defines.vh
// Purpose: constants for the rf state and link control block
// Assumes: clk_sys at 25 MHz
// Notes: times in their own unit, cycle counts derived from them
//
// How it works
// - four working states only: sleep, oscillator start-up, tune, transmit.
// - sleep turns every rf enable off; button inputs stay armed.
// - valid start edge in sleep enters start-up and enables the oscillator.
// - start-up lasts the oscillator settle time, 400 us, then tune.
// - tune lasts 370 us; amplifier off and no data sent until done.
// - transmit passes the data line level to the amplifier through the payload fifo.
// - data low for the stop time ends transmit; 20 to 90 ms, 10 ms steps.
// - soft-reset command stops an ongoing transmission within 1 ms.
// - start trigger is selectable as rising or falling data edge.
// - rising mode leaves sleep as soon as a rising edge appears.
// - data level ignored from end of hold until tune ends.
// - link data bit sampled on falling link clock edge.
// - link reset: 32 low cycles then 0x8D00; blocks start edges.
// - link release 0x8D02 turns link off, start edges accepted again.
// - soft reset 0xBD01 resets all but link, calibrates, enters sleep.
// - transmission end by timeout or soft reset returns to sleep.
`ifndef RFTC_DEFINES_VH
`define RFTC_DEFINES_VH

`define RFTC_CLK_KHZ 25000
`define RFTC_OSC_SETTLE_US 400
`define RFTC_TUNE_US 370
`define RFTC_STOP_STEP_MS 10
`define RFTC_STOP_MIN_MS 20
`define RFTC_CAL_US 100
`define RFTC_OSC_CYC ((`RFTC_OSC_SETTLE_US * `RFTC_CLK_KHZ) / 1000)
`define RFTC_TUNE_CYC ((`RFTC_TUNE_US * `RFTC_CLK_KHZ) / 1000)
`define RFTC_STEP_CYC (`RFTC_STOP_STEP_MS * `RFTC_CLK_KHZ)
`define RFTC_CAL_CYC ((`RFTC_CAL_US * `RFTC_CLK_KHZ) / 1000)

`define RFTC_CMD_LINK_RESET 16'h8D00
`define RFTC_CMD_LINK_RELEASE 16'h8D02
`define RFTC_CMD_SOFT_RESET 16'hBD01
`define RFTC_RESET_LOW_BITS 32
`define RFTC_STOP_SEL_MAX 7
`define RFTC_STOP_SEL_RST 3'h0

`define RFTC_ST_SLEEP 2'h0
`define RFTC_ST_OSC 2'h1
`define RFTC_ST_TUNE 2'h2
`define RFTC_ST_TX 2'h3

`endif

// ### design/rftc_top.v
// Purpose: rf working-state sequencer with start edge and two-wire link
// Assumes: data and link clock are asynchronous pins, double-synchronised
// Notes: payload samples pass a 16-word fifo before reaching the amplifier

`include "rftc_defines.vh"

// ==========================================================
// small fifo
module rftc_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys, // system clock
   input wire rst, // async reset, high
   input wire in_valid, // write request
   output wire in_ready, // room left
   input wire [WIDTH-1:0] in_data, // write word
   output wire out_valid, // word available
   input wire out_ready, // drain request
   output reg [WIDTH-1:0] out_data, // head word
   input wire flush // empty the fifo
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire do_wr;
   wire do_rd;
   integer i;

   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   always @* begin
      out_data = mem_q[rd_q];
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= {WIDTH{1'b0}};
         end
      end else if (flush) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            mem_q[wr_q] <= in_data;
            wr_q <= wr_q + 1'b1;
         end
         if (do_rd) begin
            rd_q <= rd_q + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ==========================================================
// sequencer top
module rftc_top #(
   parameter OSC_CYC = `RFTC_OSC_CYC,
   parameter TUNE_CYC = `RFTC_TUNE_CYC,
   parameter STEP_CYC = `RFTC_STEP_CYC,
   parameter CAL_CYC = `RFTC_CAL_CYC,
   parameter FIFO_DEPTH = 16
) (
   input wire clk_sys, // system clock 25 MHz
   input wire rst, // async reset, high
   input wire link_data_line, // raw data wire pin
   input wire link_clock_line, // link clock pin from host
   input wire start_falling, // 1: falling edge starts, 0: rising
   input wire [2:0] stop_sel, // stop time = 20 ms + 10 ms * sel
   input wire [3:0] button_in, // push-button inputs
   output reg [1:0] rf_state, // working state
   output reg osc_en, // crystal oscillator enable
   output reg synth_en, // synthesizer enable
   output reg pa_en, // power amplifier enable
   output reg pa_data, // amplifier on-off data
   output reg buttons_armed, // button sensing active
   output reg link_active, // link logic on
   output reg cal_busy, // calibration in progress
   output wire fifo_ready // fifo can take a sample
);
   localparam ST_SLEEP = `RFTC_ST_SLEEP;
   localparam ST_OSC = `RFTC_ST_OSC;
   localparam ST_TUNE = `RFTC_ST_TUNE;
   localparam ST_TX = `RFTC_ST_TX;

   // ==========================================================
   // configuration pins
   // straps are static but still cross into clk_sys
   reg [3:0] cfg_meta_q;
   reg [3:0] cfg_q;
   wire cfg_falling;
   wire [2:0] cfg_stop_sel;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_meta_q <= {1'b0, `RFTC_STOP_SEL_RST};
         cfg_q <= {1'b0, `RFTC_STOP_SEL_RST};
      end else begin
         cfg_meta_q <= {start_falling, stop_sel};
         cfg_q <= cfg_meta_q;
      end
   end

   // same two-flop latency as the data pin, so a mode change and a
   // data edge made together are judged in the new mode
   assign cfg_falling = cfg_q[3];
   assign cfg_stop_sel = cfg_q[2:0];

   // ==========================================================
   // synchronisers and edge detection
   reg [1:0] dat_sync_q;
   reg [1:0] clk_sync_q;
   reg dat_prev_q;
   reg clk_prev_q;
   wire dat_s;
   wire clk_s;
   wire dat_rise;
   wire dat_fall;
   wire clk_fall;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dat_sync_q <= 2'h0;
         clk_sync_q <= 2'h3;
         dat_prev_q <= 1'b0;
         clk_prev_q <= 1'b1;
      end else begin
         dat_sync_q <= {dat_sync_q[0], link_data_line};
         clk_sync_q <= {clk_sync_q[0], link_clock_line};
         dat_prev_q <= dat_sync_q[1];
         clk_prev_q <= clk_sync_q[1];
      end
   end

   assign dat_s = dat_sync_q[1];
   assign clk_s = clk_sync_q[1];
   assign dat_rise = dat_s && !dat_prev_q;
   assign dat_fall = !dat_s && dat_prev_q;
   assign clk_fall = !clk_s && clk_prev_q;

   // ==========================================================
   // link command shifter
   reg [15:0] sh_q;
   reg [3:0] bitcnt_q;
   reg [5:0] lowcnt_q;
   reg link_q;
   reg arm_q;
   reg soft_req_q;
   wire [15:0] sh_d;
   wire frame_end;

   // one compare per command code, received word against the code
   function cmd_is;
      input [15:0] word;
      input [15:0] code;
      begin
         cmd_is = (word == code);
      end
   endfunction

   assign sh_d = {sh_q[14:0], dat_s};
   assign frame_end = (bitcnt_q == 4'hF);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sh_q <= 16'h0000;
         bitcnt_q <= 4'h0;
         lowcnt_q <= 6'h00;
         link_q <= 1'b0;
         arm_q <= 1'b0;
         soft_req_q <= 1'b0;
      end else begin
         soft_req_q <= 1'b0;
         if (clk_fall) begin
            sh_q <= sh_d;
            bitcnt_q <= bitcnt_q + 1'b1;
            // low run of 32 bits arms a link reset frame
            if (dat_s) begin
               lowcnt_q <= 6'h00;
            end else if (lowcnt_q != 6'h3F) begin
               lowcnt_q <= lowcnt_q + 1'b1;
            end
            // the code's leading one ends the low run, so the run is
            // judged at that bit and the frame counted from there
            if (!link_q && !arm_q && dat_s &&
                lowcnt_q >= 6'd`RFTC_RESET_LOW_BITS) begin
               arm_q <= 1'b1;
               bitcnt_q <= 4'h1;
            end else if (!link_q && arm_q && frame_end) begin
               arm_q <= 1'b0;
               if (cmd_is(sh_d, `RFTC_CMD_LINK_RESET)) begin
                  link_q <= 1'b1;
                  bitcnt_q <= 4'h0;
               end
            end else if (link_q && frame_end) begin
               if (cmd_is(sh_d, `RFTC_CMD_LINK_RELEASE)) begin
                  link_q <= 1'b0;
               end else if (cmd_is(sh_d, `RFTC_CMD_SOFT_RESET)) begin
                  soft_req_q <= 1'b1;
               end
            end
         end
         // idle clock high with link off keeps frame alignment reset
         if (!link_q && !arm_q && !clk_fall) begin
            bitcnt_q <= 4'h0;
         end
      end
   end

   // ==========================================================
   // sequencer
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg [20:0] tmr_q;
   reg [23:0] low_q;
   reg [11:0] cal_q;
   wire start_edge;
   wire [23:0] stop_cyc;
   wire stop_hit;

   // rising mode is the safer default for the host
   assign start_edge = !link_q && (cfg_falling ? dat_fall : dat_rise);
   assign stop_cyc = 24'd2 * STEP_CYC[23:0] +
                     {21'h0, cfg_stop_sel} * STEP_CYC[23:0];
   assign stop_hit = (low_q >= stop_cyc);

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_SLEEP: begin
            if (start_edge && cal_q == 12'h000) begin
               st_d = ST_OSC;
            end
         end
         ST_OSC: begin
            if (tmr_q >= OSC_CYC[20:0] - 21'h1) begin
               st_d = ST_TUNE;
            end
         end
         ST_TUNE: begin
            if (tmr_q >= TUNE_CYC[20:0] - 21'h1) begin
               st_d = ST_TX;
            end
         end
         ST_TX: begin
            if (stop_hit) begin
               st_d = ST_SLEEP;
            end
         end
         default: st_d = ST_SLEEP;
      endcase
      if (soft_req_q) begin
         st_d = ST_SLEEP;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= ST_SLEEP;
         tmr_q <= 21'h0;
         low_q <= 24'h0;
         cal_q <= 12'h000;
      end else begin
         st_q <= st_d;
         if (st_d != st_q) begin
            tmr_q <= 21'h0;
         end else if (tmr_q != 21'h1FFFFF) begin
            tmr_q <= tmr_q + 1'b1;
         end
         // low timer only runs in transmit; tune-time levels ignored
         if (st_q != ST_TX || dat_s) begin
            low_q <= 24'h0;
         end else if (!stop_hit) begin
            low_q <= low_q + 1'b1;
         end
         if (soft_req_q) begin
            cal_q <= CAL_CYC[11:0];
         end else if (cal_q != 12'h000) begin
            cal_q <= cal_q - 1'b1;
         end
      end
   end

   // ==========================================================
   // payload fifo and outputs
   wire fifo_valid;
   wire fifo_data;
   wire fifo_flush;

   assign fifo_flush = (st_q != ST_TX);

   rftc_fifo #(
      .WIDTH(1),
      .DEPTH(FIFO_DEPTH),
      .AW(4)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(st_q == ST_TX),
      .in_ready(fifo_ready),
      .in_data(dat_s),
      .out_valid(fifo_valid),
      .out_ready(1'b1),
      .out_data(fifo_data),
      .flush(fifo_flush)
   );

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rf_state <= ST_SLEEP;
         osc_en <= 1'b0;
         synth_en <= 1'b0;
         pa_en <= 1'b0;
         pa_data <= 1'b0;
         buttons_armed <= 1'b1;
         link_active <= 1'b0;
         cal_busy <= 1'b0;
      end else begin
         rf_state <= st_q;
         osc_en <= (st_q != ST_SLEEP);
         synth_en <= (st_q == ST_TUNE) || (st_q == ST_TX);
         pa_en <= (st_q == ST_TX);
         pa_data <= (st_q == ST_TX) && fifo_valid && fifo_data;
         buttons_armed <= (st_q == ST_SLEEP);
         link_active <= link_q;
         cal_busy <= (cal_q != 12'h000);
      end
   end

   // buttons reach the core; the rf side only reports them armed
   wire unused_buttons;
   assign unused_buttons = |button_in;
endmodule

// ### verification/rftc_host_model.sv
// Purpose: host driving the data wire and the two-wire link
// Assumes: link clock 320 ns, idle high, data default low
// Notes: data moves 40 ns after a rise, giving 200 ns hold
`include "rftc_defines.vh"
// ==========
// host driver
module rftc_host_model (
   output logic link_data_line, // raw data wire
   output logic link_clock_line // link clock
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      link_data_line = 1'b0;
      link_clock_line = 1'b1; // still between frames
   end
   task automatic put(input logic v); // held, not pulsed
      link_data_line = v;
   endtask
   task automatic shift(input logic [15:0] v); // msb first
      for (int i = 15; i >= 0; i--) begin
         link_data_line = v[i];
         #120 link_clock_line = 1'b0; // sampled here
         #160 link_clock_line = 1'b1; // 320 ns period
         #40;
      end
      link_data_line = 1'b0; // default level
   endtask
   task automatic link_reset();
      shift(16'h0000);
      shift(16'h0000);
      shift(`RFTC_CMD_LINK_RESET);
   endtask
endmodule

// ### verification/rftc_top_properties.sv
// Purpose: port checks of the rf state sequencer
// Assumes: defaults equal the bench's shortened counts
// Notes: windows allow a cycle of sync slack
// ==========
// checker
module rftc_top_properties #(
   parameter OSC_CYC = 40,
   parameter TUNE_CYC = 30,
   parameter STEP_CYC = 50
) (
   input wire clk_sys, // clock
   input wire rst, // reset
   input wire link_data_line, // data pin
   input wire [2:0] stop_sel, // stop select
   input wire [1:0] rf_state, // state
   input wire osc_en, // oscillator
   input wire synth_en, // synthesizer
   input wire pa_en, // amplifier
   input wire pa_data, // amplifier data
   input wire buttons_armed, // buttons
   input wire link_active // link on
);
   reg [1:0] st_q;
   reg [15:0] dur_q;
   reg [15:0] low_q;
   wire [31:0] stop_cyc = (32'h2 + stop_sel) * STEP_CYC;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= 2'h0;
         dur_q <= 16'h0;
         low_q <= 16'h0;
      end else begin
         st_q <= rf_state;
         dur_q <= (rf_state != st_q) ? 16'h1 : dur_q + 16'h1;
         low_q <= (rf_state == 2'h3 && !link_data_line) ?
            low_q + 16'h1 : 16'h0;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_legal;
      rf_state != st_q |-> rf_state == 2'h0 || rf_state == st_q + 2'h1;
   endproperty
   a_legal: assert property (p_legal) else $error("bad step");
   property p_sleep_off;
      rf_state == 2'h0 && st_q == 2'h0 |->
         !osc_en && !synth_en && !pa_en && buttons_armed;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("sleep");
   property p_osc_on;
      rf_state == 2'h1 && st_q == 2'h1 |-> osc_en && !pa_en;
   endproperty
   a_osc_on: assert property (p_osc_on) else $error("osc");
   property p_osc_len;
      rf_state == 2'h2 && st_q == 2'h1 |->
         dur_q >= OSC_CYC - 1 && dur_q <= OSC_CYC + 1;
   endproperty
   a_osc_len: assert property (p_osc_len) else $error("osc len");
   property p_tune_len;
      rf_state == 2'h3 && st_q == 2'h2 |->
         dur_q >= TUNE_CYC - 1 && dur_q <= TUNE_CYC + 1;
   endproperty
   a_tune_len: assert property (p_tune_len) else $error("tune");
   property p_tune_quiet;
      rf_state == 2'h2 && st_q == 2'h2 |-> synth_en && !pa_en && !pa_data;
   endproperty
   a_tune_quiet: assert property (p_tune_quiet) else $error("pa");
   property p_tx_pa;
      rf_state == 2'h3 && st_q == 2'h3 |-> pa_en;
   endproperty
   a_tx_pa: assert property (p_tx_pa) else $error("pa off");
   property p_stop_max;
      rf_state == 2'h3 |-> low_q <= stop_cyc + 8;
   endproperty
   a_stop_max: assert property (p_stop_max) else $error("stop");
   property p_link_block;
      (link_active && rf_state == 2'h0) ##1 link_active |-> rf_state == 2'h0;
   endproperty
   a_link_block: assert property (p_link_block) else $error("link");
endmodule
bind rftc_top rftc_top_properties u_props (.clk_sys(clk_sys),
   .rst(rst), .link_data_line(link_data_line), .stop_sel(stop_sel),
   .rf_state(rf_state), .osc_en(osc_en), .synth_en(synth_en),
   .pa_en(pa_en), .pa_data(pa_data), .buttons_armed(buttons_armed),
   .link_active(link_active));

// ### verification/rftc_top_test.sv
// Purpose: self-checking bench of the rf sequencer
// Assumes: shortened counts, 40 ns clock
// Notes: buttons toggle per run though the rf side only reports them
`include "rftc_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
   err_total++; $display("unexpected t=%0t %h %h", $time, g, e); end end
// ==========
// bench
module rftc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OSC = 40;
   localparam int TUNE = 30;
   localparam int STEP = 50;
   localparam int CAL = 20;
   logic clk_sys = 1'b0;
   logic [3:0] buttons = 4'h0;
   logic rst = 1'b1;
   logic start_falling = 1'b0;
   logic [2:0] stop_sel = 3'h0;
   wire link_data_line, link_clock_line, osc_en, synth_en, pa_en, pa_data;
   wire buttons_armed, link_active, cal_busy, fifo_ready;
   wire [1:0] rf_state;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   rftc_host_model host (.link_data_line(link_data_line),
      .link_clock_line(link_clock_line));
   rftc_top #(.OSC_CYC(OSC), .TUNE_CYC(TUNE), .STEP_CYC(STEP), .CAL_CYC(CAL))
      uut (.clk_sys(clk_sys), .rst(rst), .link_data_line(link_data_line),
      .link_clock_line(link_clock_line), .start_falling(start_falling),
      .stop_sel(stop_sel), .button_in(buttons), .rf_state(rf_state),
      .osc_en(osc_en), .synth_en(synth_en), .pa_en(pa_en), .pa_data(pa_data),
      .buttons_armed(buttons_armed), .link_active(link_active),
      .cal_busy(cal_busy), .fifo_ready(fifo_ready));
   initial forever #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wait_st(input logic [1:0] s, input int lim, output int n);
      n = 0;
      while (rf_state !== s && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK(rf_state, s)
   endtask
   task automatic t_run(input logic [2:0] sel, input logic fall);
      int n;
      stop_sel = sel;
      start_falling = fall;
      buttons = ~buttons;
      host.put(fall);
      repeat (8) @(negedge clk_sys);
      `CHK(rf_state, `RFTC_ST_SLEEP)
      host.put(!fall);
      wait_st(`RFTC_ST_OSC, 8, n);
      @(negedge clk_sys);
      `CHK(osc_en, 1'b1)
      host.put(fall);
      wait_st(`RFTC_ST_TUNE, OSC + 2, n);
      `CHK(n >= OSC - 3, 1'b1)
      host.put(!fall);
      wait_st(`RFTC_ST_TX, TUNE + 2, n);
      `CHK(n >= TUNE - 3, 1'b1)
      host.put(1'b1);
      repeat (30) @(negedge clk_sys);
      `CHK({pa_en, pa_data, fifo_ready}, 3'h7)
      host.put(1'b0);
      wait_st(`RFTC_ST_SLEEP, (2 + sel) * STEP + 8, n);
      `CHK(n >= (2 + sel) * STEP, 1'b1)
      repeat (2) @(negedge clk_sys);
      `CHK({osc_en, synth_en, pa_en, buttons_armed}, 4'h1)
      $display("run sel %0d fall %0d done", sel, fall);
   endtask
   task automatic t_link();
      int n;
      stop_sel = 3'h7;
      start_falling = 1'b0;
      host.put(1'b1);
      wait_st(`RFTC_ST_TX, OSC + TUNE + 12, n);
      host.link_reset();
      repeat (2) @(negedge clk_sys);
      `CHK(link_active, 1'b1)
      host.shift(`RFTC_CMD_SOFT_RESET);
      wait_st(`RFTC_ST_SLEEP, 25000, n);
      `CHK(cal_busy, 1'b1)
      repeat (25000) @(negedge clk_sys); // host waits 1 ms
      `CHK(cal_busy, 1'b0)
      host.put(1'b1);
      repeat (8) @(negedge clk_sys);
      `CHK({rf_state, link_active}, 3'h1)
      host.put(1'b0);
      host.shift(16'h1234);
      repeat (2) @(negedge clk_sys);
      `CHK(link_active, 1'b1)
      host.shift(`RFTC_CMD_LINK_RELEASE);
      repeat (2) @(negedge clk_sys);
      `CHK(link_active, 1'b0)
      host.put(1'b1);
      wait_st(`RFTC_ST_OSC, 8, n);
      host.put(1'b0);
      wait_st(`RFTC_ST_SLEEP, OSC + TUNE + 9 * STEP + 20, n);
      $display("link test done");
   endtask
   initial begin
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      @(negedge clk_sys);
      `CHK({rf_state, osc_en, synth_en, pa_en, buttons_armed}, 6'h01)
      t_run(3'h0, 1'b0);
      t_run(3'h7, 1'b0);
      t_run(3'h2, 1'b1);
      t_link();
      summarize();
   end
endmodule
